// file: hdl/fbcs_host.sv
// Host SDRAM-style controller that drives the four-bank flash command set
`include "fbcs_params.svh"
module fbcs_host (
   // Clock and reset
   input wire logic              mclk,
   input wire logic              reset_n,
   input wire logic              clk_en,
   // User request
   input wire logic              req_valid,
   input wire fbcs_pkg::fbcs_op_t req_op,
   input wire logic [1:0]        req_bank,
   input wire logic [11:0]       req_row,
   input wire logic [11:0]       req_col,
   input wire logic [7:0]        req_code,
   input wire logic [15:0]       req_data,
   input wire logic              eng_done_ack,
   // User answer
   output logic                  req_ready,
   output logic                  rsp_valid,
   output logic [15:0]           rsp_data,
   output logic                  eng_busy,
   // Device pins
   output logic                  cke,
   output logic                  cs_n,
   output logic                  ras_n,
   output logic                  cas_n,
   output logic                  we_n,
   output logic [1:0]            ba,
   output logic [11:0]           addr,
   output logic [15:0]           dq_out,
   output logic                  dq_oe_n,
   input wire logic [15:0]       dq_in
);
   typedef enum logic [2:0] {S_IDLE, S_LCR, S_ACT, S_WAIT, S_COL, S_RDWAIT} fbcs_st_t;
   logic                rst_meta, rst_n;
   logic [15:0]         dq_meta, dq_sync;
   fbcs_st_t            st;
   fbcs_pkg::fbcs_op_t  op;
   logic [1:0]          bank_q;
   logic [11:0]         row_q, col_q;
   logic [7:0]          code_q;
   logic [15:0]         data_q;
   logic [1:0]          step;
   logic [`FBCS_CNT_W-1:0] lat;
   logic                poll;
   fbcs_bank_if         bif ();
   // ----------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dq_meta <= 16'h0000;
         dq_sync <= 16'h0000;
      end else if (clk_en) begin
         dq_meta <= dq_in;
         dq_sync <= dq_meta;
      end
   end

   fbcs_bank_track u_track (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .clk_en (clk_en),
      .bif    (bif)
   );
   // ----------------------------------------
   // Legality of a command to a bank
   // ----------------------------------------
   function automatic logic cmd_ok(input fbcs_pkg::fbcs_cmd_t c, input logic [1:0] b);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < `FBCS_BANKS; i++) begin
         if (2'(i) != b) begin
            case (bif.state[i])
               fbcs_pkg::FBCS_BK_IDLE: ;
               fbcs_pkg::FBCS_BK_ACTIVATING, fbcs_pkg::FBCS_BK_ROW_ACTIVE:
                  if (c == fbcs_pkg::FBCS_BSTTERM || c == fbcs_pkg::FBCS_LMR) ok = 1'b0;
               fbcs_pkg::FBCS_BK_READING:
                  if (c == fbcs_pkg::FBCS_WRITE || c == fbcs_pkg::FBCS_BSTTERM ||
                      c == fbcs_pkg::FBCS_LMR) ok = 1'b0;
               default: ok = 1'b0;
            endcase
            if (bif.eng_busy && bif.eng_bank == 2'(i) && c == fbcs_pkg::FBCS_WRITE)
               ok = 1'b0;
         end
      end
      if (c == fbcs_pkg::FBCS_LMR && bif.state[b] != fbcs_pkg::FBCS_BK_IDLE) ok = 1'b0;
      return ok;
   endfunction
   // Command the sequencer wants next, for the legality check
   fbcs_pkg::fbcs_cmd_t want;
   always_comb begin
      case (st)
         S_LCR:   want = fbcs_pkg::FBCS_LCR;
         S_ACT:   want = fbcs_pkg::FBCS_ACTIVE;
         S_COL:   want = (op == fbcs_pkg::FBCS_OP_READ || op == fbcs_pkg::FBCS_OP_HCS_READ ||
                          op == fbcs_pkg::FBCS_OP_STATUS) ? fbcs_pkg::FBCS_READ : fbcs_pkg::FBCS_WRITE;
         default: want = fbcs_pkg::FBCS_NOP;
      endcase
   end
   wire go = clk_en && cmd_ok(want, bank_q);
   // Step address and data: the first three software steps use fixed values on bank 0, the last one the request's
   logic [11:0] s_row, s_col;
   logic [15:0] s_dat;
   always_comb begin
      s_row = row_q;
      s_col = col_q;
      s_dat = data_q;
      if (op == fbcs_pkg::FBCS_OP_SCS_PROG) begin
         case (step)
            2'h0: begin s_row = `FBCS_SCS_ROW0; s_col = `FBCS_SCS_COL0; s_dat = `FBCS_SCS_DAT0; end
            2'h1: begin s_row = `FBCS_SCS_ROW1; s_col = `FBCS_SCS_COL1; s_dat = `FBCS_SCS_DAT1; end
            2'h2: begin s_row = `FBCS_SCS_ROW2; s_col = `FBCS_SCS_COL2; s_dat = `FBCS_SCS_DAT2; end
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st        <= S_IDLE;
         op        <= fbcs_pkg::FBCS_OP_READ;
         bank_q    <= 2'h0;
         row_q     <= 12'h000;
         col_q     <= 12'h000;
         code_q    <= 8'h00;
         data_q    <= 16'h0000;
         step      <= 2'h0;
         lat       <= '0;
         poll      <= 1'b0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data  <= 16'h0000;
         cke       <= 1'b0;
         {cs_n, ras_n, cas_n, we_n} <= fbcs_pkg::FBCS_INHIBIT;
         ba        <= 2'h0;
         addr      <= 12'h000;
         dq_out    <= 16'h0000;
         dq_oe_n   <= 1'b1;
         bif.issue <= 1'b0;
         bif.cmd   <= fbcs_pkg::FBCS_NOP;
         bif.bank  <= 2'h0;
         bif.rd_done <= 1'b0;
      end else if (clk_en) begin
         cke       <= 1'b1;
         rsp_valid <= 1'b0;
         bif.issue <= 1'b0;
         bif.rd_done <= 1'b0;
         dq_oe_n   <= 1'b1;
         {cs_n, ras_n, cas_n, we_n} <= fbcs_pkg::FBCS_NOP;
         req_ready <= (st == S_IDLE) && !req_valid;
         case (st)
            S_IDLE: if (req_valid && cke &&
                       !(bif.eng_busy && req_op != fbcs_pkg::FBCS_OP_READ &&
                         req_op != fbcs_pkg::FBCS_OP_STATUS)) begin
               op     <= req_op;
               bank_q <= (req_op == fbcs_pkg::FBCS_OP_SCS_PROG) ? `FBCS_SCS_BANK : req_bank;
               row_q  <= req_row;
               col_q  <= req_col;
               code_q <= req_code;
               data_q <= req_data;
               step   <= 2'h0;
               poll   <= req_op == fbcs_pkg::FBCS_OP_STATUS;
               st     <= (req_op == fbcs_pkg::FBCS_OP_READ && bif.eng_busy &&
                          req_bank == bif.eng_bank) ? S_COL :
                         (req_op == fbcs_pkg::FBCS_OP_READ || req_op == fbcs_pkg::FBCS_OP_SCS_PROG) ? S_ACT :
                         (req_op == fbcs_pkg::FBCS_OP_LMR) ? S_COL : S_LCR;
            end
            S_LCR: if (go) begin
               {cs_n, ras_n, cas_n, we_n} <= fbcs_pkg::FBCS_LCR;
               ba   <= bank_q;
               addr <= {4'h0, code_q};
               bif.issue <= 1'b1;
               bif.cmd   <= fbcs_pkg::FBCS_LCR;
               bif.bank  <= bank_q;
               st <= (op == fbcs_pkg::FBCS_OP_HCS_LONE) ? S_IDLE : S_ACT;
            end
            S_ACT: if (go) begin
               {cs_n, ras_n, cas_n, we_n} <= fbcs_pkg::FBCS_ACTIVE;
               ba   <= bank_q;
               addr <= s_row;
               bif.issue <= 1'b1;
               bif.cmd   <= fbcs_pkg::FBCS_ACTIVE;
               bif.bank  <= bank_q;
               st <= S_WAIT;
            end
            S_WAIT: if (!bif.issue && bif.state[bank_q] == fbcs_pkg::FBCS_BK_ROW_ACTIVE) st <= S_COL;
            S_COL: if (op == fbcs_pkg::FBCS_OP_LMR) begin
               if (!bif.any_open) begin
                  {cs_n, ras_n, cas_n, we_n} <= fbcs_pkg::FBCS_LMR;
                  addr <= row_q;
                  st   <= S_IDLE;
               end else if (!bif.issue && cmd_ok(fbcs_pkg::FBCS_ACTTERM, bif.open_bank)) begin
                  {cs_n, ras_n, cas_n, we_n} <= fbcs_pkg::FBCS_ACTTERM;
                  ba        <= bif.open_bank;
                  bif.issue <= 1'b1;
                  bif.cmd   <= fbcs_pkg::FBCS_ACTTERM;
                  bif.bank  <= bif.open_bank;
               end
            end else if (go) begin
               {cs_n, ras_n, cas_n, we_n} <= want;
               ba   <= bank_q;
               addr <= s_col;
               bif.issue <= 1'b1;
               bif.cmd   <= want;
               bif.bank  <= bank_q;
               if (want == fbcs_pkg::FBCS_WRITE) begin
                  dq_out  <= (op == fbcs_pkg::FBCS_OP_HCS_WRITE) ? {8'h00, code_q} : s_dat;
                  dq_oe_n <= 1'b0;
                  if (op == fbcs_pkg::FBCS_OP_SCS_PROG && step != 2'(`FBCS_SCS_STEPS)) begin
                     step <= step + 2'h1;
                     st   <= S_ACT;
                  end else begin
                     st <= S_IDLE;
                  end
               end else begin
                  // Device latency plus both synchroniser stages on the data pins
                  lat <= `FBCS_CNT_W'(`FBCS_RD_LAT + `FBCS_SYNC_STAGES);
                  st  <= S_RDWAIT;
               end
            end
            S_RDWAIT: if (lat == '0) begin
               rsp_valid   <= 1'b1;
               rsp_data    <= dq_sync;
               bif.rd_done <= 1'b1;
               poll        <= 1'b0;
               st          <= S_IDLE;
            end else begin
               lat <= lat - `FBCS_CNT_W'(1);
            end
            default: st <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Engine busy: from sequence launch until ready bit seen or eng_done_ack
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bif.eng_busy <= 1'b0;
         bif.eng_bank <= 2'h0;
         eng_busy     <= 1'b0;
      end else if (clk_en) begin
         if (st == S_RDWAIT && lat == '0 && poll && dq_sync[`FBCS_RDY_BIT])
            bif.eng_busy <= 1'b0;
         else if (eng_done_ack)
            bif.eng_busy <= 1'b0;
         if (st == S_COL && go && want == fbcs_pkg::FBCS_WRITE &&
             (op == fbcs_pkg::FBCS_OP_HCS_WRITE ||
              (op == fbcs_pkg::FBCS_OP_SCS_PROG && step == 2'(`FBCS_SCS_STEPS)))) begin
            bif.eng_busy <= 1'b1;
            bif.eng_bank <= bank_q;
         end
         eng_busy <= bif.eng_busy;
      end
   end
endmodule

// file: hdl/fbcs_params.svh
// Constants for the flash bank command sequencer host controller
`ifndef FBCS_PARAMS_SVH
`define FBCS_PARAMS_SVH
`define FBCS_CLK_PERIOD_NS   40
`define FBCS_TRCD_NS         20
`define FBCS_TRCD_CYC        ((`FBCS_TRCD_NS + `FBCS_CLK_PERIOD_NS - 1) / `FBCS_CLK_PERIOD_NS)
`define FBCS_CNT_W           4
`define FBCS_BANKS           4
`define FBCS_CMD_W           4
`define FBCS_LCR_DATA_LSB    0
`define FBCS_SCS_STEPS       3
`define FBCS_SCS_BANK        2'h0
`define FBCS_SCS_ROW0        12'h000
`define FBCS_SCS_COL0        12'h055
`define FBCS_SCS_DAT0        16'h0000
`define FBCS_SCS_ROW1        12'h055
`define FBCS_SCS_COL1        12'h02A
`define FBCS_SCS_DAT1        16'h0055
`define FBCS_SCS_ROW2        12'h080
`define FBCS_SCS_COL2        12'h040
`define FBCS_SCS_DAT2        16'h00A0
`define FBCS_RDY_BIT         7
`define FBCS_RD_LAT          2
`define FBCS_SYNC_STAGES     2
`endif

// file: hdl/fbcs_pkg.sv
// Types shared by the flash bank command sequencer host controller
package fbcs_pkg;
   // Pin encoding {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      FBCS_INHIBIT = 4'hF,
      FBCS_NOP     = 4'h7,
      FBCS_ACTIVE  = 4'h3,
      FBCS_READ    = 4'h5,
      FBCS_WRITE   = 4'h4,
      FBCS_ACTTERM = 4'h2,
      FBCS_LCR     = 4'h1,
      FBCS_LMR     = 4'h0,
      FBCS_BSTTERM = 4'h6
   } fbcs_cmd_t;
   // User request kinds
   typedef enum logic [2:0] {
      FBCS_OP_READ,
      FBCS_OP_HCS_LONE,
      FBCS_OP_HCS_READ,
      FBCS_OP_HCS_WRITE,
      FBCS_OP_SCS_PROG,
      FBCS_OP_LMR,
      FBCS_OP_STATUS
   } fbcs_op_t;
   typedef enum logic [1:0] {
      FBCS_BK_IDLE,
      FBCS_BK_ACTIVATING,
      FBCS_BK_ROW_ACTIVE,
      FBCS_BK_READING
   } fbcs_bank_t;
endpackage

// file: hdl/fbcs_bank_if.sv
// Bank tracker carrier between the sequencer and its bank tracker
interface fbcs_bank_if;
   logic                 issue;
   fbcs_pkg::fbcs_cmd_t  cmd;
   logic [1:0]           bank;
   logic                 rd_done;
   logic                 eng_busy;
   logic [1:0]           eng_bank;
   logic                 any_open;
   logic [1:0]           open_bank;
   fbcs_pkg::fbcs_bank_t state [4];
   modport seq (output issue, output cmd, output bank, output rd_done, output eng_busy,
                output eng_bank, input state, input any_open, input open_bank);
   modport trk (input issue, input cmd, input bank, input rd_done, input eng_busy,
                input eng_bank, output state, output any_open, output open_bank);
endinterface

// file: hdl/fbcs_bank_track.sv
// Per-bank state tracker kept by the host to judge which commands are legal
`include "fbcs_params.svh"
module fbcs_bank_track (
   // Clocking
   input wire logic      mclk,
   input wire logic      rst_n,
   input wire logic      clk_en,
   // Sequencer side
   fbcs_bank_if.trk      bif
);
   // Lowest bank still open, so a mode load can close the banks one at a time
   always_comb begin
      bif.any_open  = 1'b0;
      bif.open_bank = 2'h0;
      for (int i = `FBCS_BANKS - 1; i >= 0; i--) begin
         if (bif.state[i] != fbcs_pkg::FBCS_BK_IDLE) begin
            bif.any_open  = 1'b1;
            bif.open_bank = 2'(i);
         end
      end
   end
   genvar g;
   generate
      for (g = 0; g < `FBCS_BANKS; g++) begin : g_bank
         logic [`FBCS_CNT_W-1:0] cnt;
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               bif.state[g] <= fbcs_pkg::FBCS_BK_IDLE;
               cnt          <= '0;
            end else if (clk_en) begin
               // tRCD countdown turns activating into row active
               if (bif.state[g] == fbcs_pkg::FBCS_BK_ACTIVATING) begin
                  if (cnt <= `FBCS_CNT_W'(1))
                     bif.state[g] <= fbcs_pkg::FBCS_BK_ROW_ACTIVE;
                  else
                     cnt <= cnt - `FBCS_CNT_W'(1);
               end
               if (bif.rd_done && bif.state[g] == fbcs_pkg::FBCS_BK_READING)
                  bif.state[g] <= fbcs_pkg::FBCS_BK_ROW_ACTIVE;
               if (bif.issue && bif.bank == 2'(g)) begin
                  case (bif.cmd)
                     fbcs_pkg::FBCS_ACTIVE: begin
                        bif.state[g] <= fbcs_pkg::FBCS_BK_ACTIVATING;
                        cnt          <= `FBCS_CNT_W'(`FBCS_TRCD_CYC);
                     end
                     fbcs_pkg::FBCS_READ:    bif.state[g] <= fbcs_pkg::FBCS_BK_READING;
                     fbcs_pkg::FBCS_ACTTERM: bif.state[g] <= fbcs_pkg::FBCS_BK_IDLE;
                     fbcs_pkg::FBCS_BSTTERM: bif.state[g] <= fbcs_pkg::FBCS_BK_ROW_ACTIVE;
                     default: ;
                  endcase
               end
            end
         end
      end
   endgenerate
endmodule

// file: tb/fbcs_host_properties.sv
// Pin-level properties of the flash bank host controller
module fbcs_host_properties (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        reset_n,
   // Device pins and status
   input wire logic        cke,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [1:0]  ba,
   input wire logic        dq_oe_n,
   input wire logic        rsp_valid,
   input wire logic        eng_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cmd;
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   deselect_idle_a: assert property (cs_n |-> cmd == 4'hF)
      else $error("strobes move while deselected");
   cke_hold_a: assert property ($past(cke) |-> cke)
      else $error("clock enable dropped after start");
   cmd_cke_a: assert property (!(cmd inside {4'hF, 4'h7}) |-> cke && $past(cke))
      else $error("command without two enabled edges");
   lmr_idle_a: assert property (cmd == 4'h0 |-> !eng_busy)
      else $error("mode load while engine busy");
   dq_drive_a: assert property (!dq_oe_n == (cmd == 4'h4))
      else $error("data bus driven outside a write");
   rcd_wait_a: assert property (cmd == 4'h3 |=> !(cmd inside {4'h5, 4'h4} && ba == $past(ba)))
      else $error("column access before row delay");
   seq_bank_a: assert property (cmd == 4'h3 && $past(cmd) == 4'h1 |-> ba == $past(ba))
      else $error("sequence steps on different banks");
   read_rsp_a: assert property (cmd == 4'h5 |-> ##[2:10] rsp_valid)
      else $error("read without returned data");
   write_busy_a: assert property ($rose(eng_busy) |-> $past(cmd) == 4'h4)
      else $error("engine busy rose without a write");
endmodule
bind fbcs_host fbcs_host_properties u_fbcs_host_properties (
   .mclk(mclk), .reset_n(reset_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
   .we_n(we_n), .ba(ba), .dq_oe_n(dq_oe_n), .rsp_valid(rsp_valid), .eng_busy(eng_busy)
);

// file: tb/fbcs_flash_model.sv
// Behavioural four-bank flash device answering the host controller pins
module fbcs_flash_model #(
   parameter int          ENG_CYC   = 200,
   parameter logic [7:0]  STAT_CODE = 8'h70
) (
   // Clock and reset
   input wire logic         mclk,
   input wire logic         rst_n,
   // Host pins
   input wire logic         cke,
   input wire logic         cs_n,
   input wire logic         ras_n,
   input wire logic         cas_n,
   input wire logic         we_n,
   input wire logic [1:0]   ba,
   input wire logic [11:0]  addr,
   input wire logic [15:0]  dq_out,
   input wire logic         dq_oe_n,
   // Device data
   output logic [15:0]      dq_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  cmd;
   logic [11:0] row [4];
   logic [7:0]  code;
   logic        lcr_pend, stat_mode, busy;
   logic [1:0]  eng_bank, scs_step, rd_v;
   logic [15:0] rd_data, last;
   int          eng_cnt;
   logic [11:0] scs_col [3] = '{12'h055, 12'h02A, 12'h040};
   logic [15:0] scs_dat [3] = '{16'h0000, 16'h0055, 16'h00A0};
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   assign busy = eng_cnt != 0;
   // Released bus shows the inverse of the last word so a stale sample fails
   assign dq_in = rd_v[1] ? rd_data : ~last;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lcr_pend <= 1'h0;
         stat_mode <= 1'h0;
         scs_step <= 2'h0;
         rd_v <= 2'h0;
         eng_cnt <= 0;
         last <= 16'h0000;
      end else begin
         rd_v <= {rd_v[0], 1'h0};
         if (rd_v[1]) last <= rd_data;
         if (busy) eng_cnt <= eng_cnt - 1;
         // Inhibit, no-op and unlisted codes leave every bank as it was
         if (cke) begin
            case (cmd)
               4'h3: if (!(busy && ba == eng_bank)) row[ba] <= addr;
               4'h1: begin
                  code <= addr[7:0];
                  lcr_pend <= 1'h1;
                  stat_mode <= addr[7:0] == STAT_CODE;
               end
               4'h5: begin
                  rd_v[0] <= 1'h1;
                  rd_data <= stat_mode ? {8'h00, !busy, 7'h00} : {ba, row[ba][5:0], addr[7:0]};
                  stat_mode <= 1'h0;
                  lcr_pend <= 1'h0;
               end
               4'h4: begin
                  if (!busy && (lcr_pend ? dq_out[7:0] == code : (ba == 2'h0 && scs_step == 2'h3))) begin
                     eng_cnt <= ENG_CYC;
                     eng_bank <= ba;
                  end
                  scs_step <= (!lcr_pend && ba == 2'h0 && scs_step < 2'h3 && addr == scs_col[scs_step]
                               && dq_out == scs_dat[scs_step]) ? scs_step + 2'h1 : 2'h0;
                  lcr_pend <= 1'h0;
               end
               default: ;
            endcase
         end
      end
   end
endmodule

// file: tb/tb_fbcs_host.sv
// Self-checking bench for the flash bank host controller
module tb_fbcs_host;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] STAT_CODE = 8'h70;
   logic                  mclk, reset_n, clk_en, req_valid, eng_done_ack;
   fbcs_pkg::fbcs_op_t    req_op;
   logic [1:0]            req_bank, ba;
   logic [11:0]           req_row, req_col, addr;
   logic [7:0]            req_code;
   logic [15:0]           req_data, rsp_data, dq_out, dq_in, got;
   logic                  req_ready, rsp_valid, eng_busy, cke, cs_n, ras_n, cas_n, we_n, dq_oe_n;
   int                    bad_count, check_count;
   fbcs_host u_fbcs_host (
      .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .req_valid(req_valid), .req_op(req_op),
      .req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_code(req_code),
      .req_data(req_data), .eng_done_ack(eng_done_ack), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .eng_busy(eng_busy), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .ba(ba), .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
   fbcs_flash_model #(.STAT_CODE(STAT_CODE)) u_fbcs_flash_model (
      .mclk(mclk), .rst_n(reset_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .ba(ba), .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
   initial begin
      mclk = 1'h0;
      forever #20 mclk = ~mclk;
   end
   function automatic logic [15:0] word(input logic [1:0] b, input logic [11:0] r, c);
      return {b, r[5:0], c[7:0]};
   endfunction
   task automatic check(input string name, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------
   // Request drivers
   // ----------------------------------------
   // Raise a request once the controller shows idle or after 60 cycles, then hold it one edge
   task automatic send(input fbcs_pkg::fbcs_op_t op, input logic [1:0] b, input logic [11:0] r, c,
                       input logic [7:0] code, input logic [15:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'h1 && n < 60) begin @(negedge mclk); n++; end
      if (n >= 60) check("request slot", 16'h0000, 16'h0001);
      req_op = op;
      {req_bank, req_row, req_col, req_code, req_data} = {b, r, c, code, d};
      req_valid = 1'h1;
      @(negedge mclk);
      req_valid = 1'h0;
   endtask
   task automatic rd(input fbcs_pkg::fbcs_op_t op, input logic [1:0] b, input logic [11:0] r, c,
                     input logic [7:0] code);
      int n;
      send(op, b, r, c, code, 16'h0000);
      n = 0;
      while (rsp_valid !== 1'h1 && n < 40) begin @(negedge mclk); n++; end
      got = (n < 40) ? rsp_data : 16'hXXXX;
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         rd(fbcs_pkg::FBCS_OP_STATUS, 2'h1, 12'h000, 12'h000, STAT_CODE);
         n++;
      end while (got[7] !== 1'h1 && n < 40);
      n = 0;
      while (eng_busy !== 1'h0 && n < 10) begin @(negedge mclk); n++; end
      check("engine idle", {14'h0000, got[7], eng_busy}, 16'h0002);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_array_read();
      for (int b = 0; b < 4; b++) begin
         rd(fbcs_pkg::FBCS_OP_READ, 2'(b), 12'h3C0 + 12'(b), 12'h0FF - 12'(b), 8'h00);
         check("array word", got, word(2'(b), 12'h3C0 + 12'(b), 12'h0FF - 12'(b)));
      end
      rd(fbcs_pkg::FBCS_OP_STATUS, 2'h1, 12'h000, 12'h000, STAT_CODE);
      check("ready when idle", {15'h0000, got[7]}, 16'h0001);
   endtask
   task automatic t_hcs_write();
      send(fbcs_pkg::FBCS_OP_HCS_WRITE, 2'h0, 12'h011, 12'h003, 8'hD0, 16'h0000);
      rd(fbcs_pkg::FBCS_OP_READ, 2'h2, 12'h0AB, 12'h0CD, 8'h00);
      check("busy after write", {15'h0000, eng_busy}, 16'h0001);
      check("other bank read", got, word(2'h2, 12'h0AB, 12'h0CD));
      rd(fbcs_pkg::FBCS_OP_READ, 2'h0, 12'h022, 12'h005, 8'h00);
      check("engine bank read", got, word(2'h0, 12'h011, 12'h005));
      rd(fbcs_pkg::FBCS_OP_STATUS, 2'h1, 12'h000, 12'h000, STAT_CODE);
      check("ready while busy", {15'h0000, got[7]}, 16'h0000);
      wait_ready();
   endtask
   task automatic t_scs();
      send(fbcs_pkg::FBCS_OP_SCS_PROG, 2'h0, 12'h000, 12'h000, 8'h00, 16'h1234);
      rd(fbcs_pkg::FBCS_OP_STATUS, 2'h1, 12'h000, 12'h000, STAT_CODE);
      check("program started", {15'h0000, got[7]}, 16'h0000);
      wait_ready();
   endtask
   task automatic t_lone_lmr();
      send(fbcs_pkg::FBCS_OP_HCS_LONE, 2'h1, 12'h000, 12'h000, 8'h50, 16'h0000);
      send(fbcs_pkg::FBCS_OP_LMR, 2'h0, 12'h023, 12'h000, 8'h00, 16'h0000);
      rd(fbcs_pkg::FBCS_OP_READ, 2'h3, 12'h000, 12'h000, 8'h00);
      check("read after mode load", got, word(2'h3, 12'h000, 12'h000));
   endtask
   initial begin
      {reset_n, req_valid, eng_done_ack} = 3'h0;
      clk_en = 1'h1;
      req_op = fbcs_pkg::FBCS_OP_READ;
      {req_bank, req_row, req_col, req_code, req_data} = '0;
      bad_count = 0;
      check_count = 0;
      repeat (6) @(negedge mclk);
      reset_n = 1'h1;
      repeat (4) @(negedge mclk);
      t_array_read();
      t_hcs_write();
      t_scs();
      t_lone_lmr();
      tally_and_finish();
   end
   // Whole run is a few hundred cycles; this bound only cuts a hang
   initial begin
      #(40 * 20000);
      bad_count++;
      tally_and_finish();
   end
endmodule
